//--- logic/flash_command_register_unit.v
`timescale 1ns/10ps
`include "flash_cmd_defines.vh"

// ----------------------------------------------------------------------
// Flash command register unit
// ----------------------------------------------------------------------
//
// Contract
// - Execute code only with key 0xa5 written.
// - Wrong key: no execution, set program error.
// - Command while busy sets program error.
// - System bus first; run when both idle.
// - Key bit zero reads one until issued.
// - Address field counts halfwords, not bytes.
// - Code 0x02 erases addressed main row.
// - Code 0x04 writes page buffer to page.
// - Code 0x05 erases addressed auxiliary row.
// - Aux erase needs clear security, user row.
// - Command code sits in bits 6:0.
// - Key in bits 15:8; reset zero.
// - 8, 16, 32-bit and partial lane access.
// - Enable-protected registers ignore writes while enabled.
// - Main row erase (0x02) of locked region skipped, lock error.
module flash_command_register_unit #(
  parameter [15:0] PAGE_COUNT = 16'h0400,
  parameter [2:0] PAGE_SIZE_CODE = 3'h3,
  parameter [11:0] AUX_PAGE_COUNT = 12'h020,
  parameter REGION_SHIFT = 12,
  parameter ROW_SHIFT = 8,
  parameter [22:0] USER_ROW_BYTE_ADDR = 23'h400000
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [5:0] paddr,
  input wire [3:0] pstrb,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  input wire module_enable,
  input wire sysbus_busy,
  input wire security_bit,
  input wire [15:0] lock_bits,
  input wire page_loaded,
  input wire flash_busy,
  input wire flash_done,
  output reg flash_start,
  output reg [6:0] flash_op,
  output reg [22:0] flash_byte_addr
);

  // --------------------------------------------------------------------
  // States of the command sequencer
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001; // Nothing outstanding.
  localparam [2:0] ST_PEND = 3'b010; // Accepted, waiting for idle buses.
  localparam [2:0] ST_RUN = 3'b100;  // Handed to the array.

  // Word address compare, used by every register decode below.
  function reg_hit;
    input [5:0] a;
    input [5:0] ofs;
    begin
      reg_hit = (a[5:2] == ofs[5:2]);
    end
  endfunction

  reg [2:0] state; // Sequencer state.
  reg [6:0] cmd_code; // Command code field.
  reg [7:0] cmd_key; // Command key field as stored.
  reg [31:0] config_word; // Configuration register.
  reg [1:0] irq_en; // Interrupt enable bits.
  reg ready_flag; // No operation in progress.
  reg error_flag; // Sticky error indication.
  reg program_error_flag; // Sticky program error.
  reg lock_error_flag; // Sticky lock error.
  reg [21:0] target_addr; // Halfword address of the target.
  reg [31:0] read_value; // Combinational read mux.
  wire [31:0] merged; // Bus data merged with current contents.
  wire bus_write; // Access phase of a write.
  wire bus_setup; // Setup phase of any access.
  wire [22:0] byte_addr; // Target address in bytes.
  wire [3:0] region_idx; // Lock region of the target.
  wire region_locked; // Target region is locked.
  wire user_row; // Target lies in the user row.
  wire key_ok; // Written key equals the key value.
  wire cmd_write; // Write touching the key lane.
  wire prog_err_set; // Program error event this cycle.
  wire lock_err_set; // Lock error event this cycle.
  wire launch_ok; // Buses idle, pending command may go.
  wire w1c_flags; // Write to the flag register.
  wire w1c_status; // Write to the status register.

  // --------------------------------------------------------------------
  // Bus handshake
  // --------------------------------------------------------------------
  // Ready follows the clock enable, so a frozen block stretches the
  // transfer instead of losing it.
  assign pready = ce;
  assign bus_write = psel & penable & pwrite & ce;
  assign bus_setup = psel & ~penable & ce;

  lane_merge #(
    .LANES(4)
  ) u_lane_merge (
    .old_word(read_value),
    .new_word(pwdata),
    .lane_strb(pstrb),
    .merged(merged)
  );

  // --------------------------------------------------------------------
  // Address arithmetic
  // --------------------------------------------------------------------
  // halfword units
  assign byte_addr = {target_addr, 1'b0};
  assign region_idx = byte_addr[REGION_SHIFT +: 4];
  // A cleared lock bit marks its region as locked.
  assign region_locked = ~lock_bits[region_idx];
  assign user_row = (byte_addr >> ROW_SHIFT) == (USER_ROW_BYTE_ADDR >> ROW_SHIFT);

  // --------------------------------------------------------------------
  // Command write decode
  // --------------------------------------------------------------------
  assign cmd_write = bus_write & reg_hit(paddr, `OFS_COMMAND_CONTROL) & pstrb[`LANE_KEY];
  assign key_ok = (merged[`KEY_MSB:`KEY_LSB] == `KEY_VALUE);
  assign launch_ok = (state == ST_PEND) & ~sysbus_busy & ~flash_busy;
  assign w1c_flags = bus_write & reg_hit(paddr, `OFS_IRQ_FLAGS) & pstrb[0];
  assign w1c_status = bus_write & reg_hit(paddr, `OFS_CONTROLLER_STATUS) & pstrb[0];

  // aux row guard
  // Reserved codes are stopped at launch, never reach the array, and count as program errors.
  assign prog_err_set = (cmd_write & ~key_ok) |
                        (cmd_write & key_ok & pstrb[`LANE_CODE] & (state != ST_IDLE)) |
                        (launch_ok & (cmd_code == `CMD_AUX_ROW_WIPE) &
                         (security_bit | ~user_row)) |
                        (launch_ok & (cmd_code != `CMD_AUX_ROW_WIPE) &
                         (cmd_code != `CMD_ROW_WIPE) & (cmd_code != `CMD_PAGE_WRITE));

  assign lock_err_set = launch_ok & (cmd_code == `CMD_ROW_WIPE) & region_locked;

  // --------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------
  // A command is accepted at the write, waits for both the system bus and
  // the array to be idle, and then either launches or resolves as error.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cmd_code <= `CODE_RESET;
      cmd_key <= `KEY_RESET;
      ready_flag <= 1'b1;
      flash_start <= 1'b0;
      flash_op <= `CODE_RESET;
      flash_byte_addr <= {`ADDR_RESET, 1'b0};
    end else if (ce) begin
      flash_start <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (bus_write & reg_hit(paddr, `OFS_COMMAND_CONTROL) & pstrb[`LANE_CODE]) begin
            cmd_code <= merged[`CODE_MSB:`CODE_LSB];
          end
          if (cmd_write) begin
            cmd_key <= merged[`KEY_MSB:`KEY_LSB];
          end
          // same access
          // A key alone, without the code lane, triggers nothing.
          if (cmd_write & key_ok & pstrb[`LANE_CODE]) begin
            state <= ST_PEND;
            ready_flag <= 1'b0;
          end
        end
        ST_PEND: begin
          if (launch_ok) begin
            cmd_key <= `KEY_RESET;
            if (prog_err_set | lock_err_set) begin
              state <= ST_IDLE;
              ready_flag <= 1'b1;
            end else begin
              state <= ST_RUN;
              flash_start <= 1'b1;
              flash_op <= cmd_code;
              flash_byte_addr <= byte_addr;
            end
          end
        end
        ST_RUN: begin
          if (flash_done) begin
            state <= ST_IDLE;
            ready_flag <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          ready_flag <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Sticky flags
  // --------------------------------------------------------------------
  // Writing one clears a flag, but an event in the same cycle wins so a
  // fault is never lost to a racing clear.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      program_error_flag <= 1'b0;
      lock_error_flag <= 1'b0;
      error_flag <= 1'b0;
    end else if (ce) begin
      if (prog_err_set) begin
        program_error_flag <= 1'b1;
      end else if (w1c_status & pwdata[`ST_PROGRAM_ERROR_FLAG_BIT]) begin
        program_error_flag <= 1'b0;
      end
      if (lock_err_set) begin
        lock_error_flag <= 1'b1;
      end else if (w1c_status & pwdata[`ST_LOCK_ERROR_FLAG_BIT]) begin
        lock_error_flag <= 1'b0;
      end
      if (prog_err_set | lock_err_set) begin
        error_flag <= 1'b1;
      end else if (w1c_flags & pwdata[`IRQ_ERROR_BIT]) begin
        error_flag <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Plain read/write registers
  // --------------------------------------------------------------------
  // Configuration is enable-protected; the interrupt enables use the
  // set/clear pair so software never needs a read-modify-write.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_word <= `CONFIG_RESET;
      irq_en <= `IRQ_EN_RESET;
      target_addr <= `ADDR_RESET;
    end else if (ce) begin
      if (bus_write & reg_hit(paddr, `OFS_CONFIG_CONTROL) & ~module_enable) begin
        config_word <= merged & `CONFIG_WMASK;
      end
      if (bus_write & reg_hit(paddr, `OFS_IRQ_ENABLE_SET) & pstrb[0]) begin
        irq_en <= irq_en | pwdata[`IRQ_ERROR_BIT:`IRQ_READY_BIT];
      end
      if (bus_write & reg_hit(paddr, `OFS_IRQ_ENABLE_CLEAR) & pstrb[0]) begin
        irq_en <= irq_en & ~pwdata[`IRQ_ERROR_BIT:`IRQ_READY_BIT];
      end
      // The address may not move under a command already accepted.
      if (bus_write & reg_hit(paddr, `OFS_TARGET_ADDRESS) & (state == ST_IDLE)) begin
        target_addr <= merged[`ADDR_MSB:`ADDR_LSB];
      end
    end
  end

  // --------------------------------------------------------------------
  // Read multiplexer
  // --------------------------------------------------------------------
  // Unmapped offsets and reserved bits read as zero.
  always @* begin
    read_value = `WORD_ZERO;
    if (reg_hit(paddr, `OFS_COMMAND_CONTROL)) begin
      read_value[`CODE_MSB:`CODE_LSB] = cmd_code;
      read_value[`KEY_MSB:`KEY_LSB] = cmd_key;
      read_value[`KEY_LSB] = cmd_key[0] | (state == ST_PEND);
    end else if (reg_hit(paddr, `OFS_CONFIG_CONTROL)) begin
      read_value = config_word;
    end else if (reg_hit(paddr, `OFS_GEOMETRY_PARAMETERS)) begin
      read_value[`GEO_PAGES_MSB:`GEO_PAGES_LSB] = PAGE_COUNT;
      read_value[`GEO_PSZ_MSB:`GEO_PSZ_LSB] = PAGE_SIZE_CODE;
      read_value[`GEO_AUXP_MSB:`GEO_AUXP_LSB] = AUX_PAGE_COUNT;
    end else if (reg_hit(paddr, `OFS_IRQ_ENABLE_CLEAR) |
                 reg_hit(paddr, `OFS_IRQ_ENABLE_SET)) begin
      read_value[`IRQ_ERROR_BIT:`IRQ_READY_BIT] = irq_en;
    end else if (reg_hit(paddr, `OFS_IRQ_FLAGS)) begin
      read_value[`IRQ_READY_BIT] = ready_flag;
      read_value[`IRQ_ERROR_BIT] = error_flag;
    end else if (reg_hit(paddr, `OFS_CONTROLLER_STATUS)) begin
      read_value[`ST_LOAD_BIT] = page_loaded;
      read_value[`ST_PROGRAM_ERROR_FLAG_BIT] = program_error_flag;
      read_value[`ST_LOCK_ERROR_FLAG_BIT] = lock_error_flag;
      read_value[`ST_SB_BIT] = security_bit;
    end else if (reg_hit(paddr, `OFS_TARGET_ADDRESS)) begin
      read_value[`ADDR_MSB:`ADDR_LSB] = target_addr;
    end else if (reg_hit(paddr, `OFS_REGION_LOCK_BITS)) begin
      read_value[`LOCK_MSB:`LOCK_LSB] = lock_bits;
    end
  end

  // Read data is captured in the setup phase and holds through access.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= `WORD_ZERO;
    end else if (bus_setup & ~pwrite) begin
      prdata <= read_value;
    end
  end

endmodule // flash_command_register_unit

//--- logic/flash_cmd_defines.vh
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// ----------------------------------------------------------------------
// Register word offsets (byte addresses on the peripheral bus)
// ----------------------------------------------------------------------
`define OFS_COMMAND_CONTROL 6'h00
`define OFS_CONFIG_CONTROL 6'h04
`define OFS_GEOMETRY_PARAMETERS 6'h08
`define OFS_IRQ_ENABLE_CLEAR 6'h0c
`define OFS_IRQ_ENABLE_SET 6'h10
`define OFS_IRQ_FLAGS 6'h14
`define OFS_CONTROLLER_STATUS 6'h18
`define OFS_TARGET_ADDRESS 6'h1c
`define OFS_REGION_LOCK_BITS 6'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CODE_MSB 6
`define CODE_LSB 0
`define KEY_MSB 15
`define KEY_LSB 8
`define IRQ_READY_BIT 0
`define IRQ_ERROR_BIT 1
`define ST_PRM_BIT 0
`define ST_LOAD_BIT 1
`define ST_PROGRAM_ERROR_FLAG_BIT 2
`define ST_LOCK_ERROR_FLAG_BIT 3
`define ST_NVME_BIT 4
`define ST_SB_BIT 8
`define ADDR_MSB 21
`define ADDR_LSB 0
`define GEO_PAGES_MSB 15
`define GEO_PAGES_LSB 0
`define GEO_PSZ_MSB 18
`define GEO_PSZ_LSB 16
`define GEO_AUXP_MSB 31
`define GEO_AUXP_LSB 20
`define LOCK_MSB 15
`define LOCK_LSB 0
`define LANE_CODE 0
`define LANE_KEY 1

// ----------------------------------------------------------------------
// Values, codes and reset contents
// ----------------------------------------------------------------------
`define KEY_VALUE 8'ha5
`define CMD_ROW_WIPE 7'h02
`define CMD_PAGE_WRITE 7'h04
`define CMD_AUX_ROW_WIPE 7'h05
`define CODE_RESET 7'h00
`define KEY_RESET 8'h00
`define CONFIG_RESET 32'h00000080
`define CONFIG_WMASK 32'h0007039e
`define ADDR_RESET 22'h000000
`define IRQ_EN_RESET 2'h0
`define WORD_ZERO 32'h00000000

`endif

//--- logic/lane_merge.v
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// Byte lane merge
// ----------------------------------------------------------------------
// Builds the word a register takes after a partial write: lanes whose
// strobe is high come from the bus, the others keep the old contents.
// This is what lets 8-bit quarters and 16-bit halves be written alone.
module lane_merge #(
  parameter LANES = 4
) (
  input wire [LANES*8-1:0] old_word,
  input wire [LANES*8-1:0] new_word,
  input wire [LANES-1:0] lane_strb,
  output wire [LANES*8-1:0] merged
);

  genvar i;

  // One multiplexer per byte lane.
  generate
    for (i = 0; i < LANES; i = i + 1) begin : g_lane
      assign merged[i*8 +: 8] = lane_strb[i] ? new_word[i*8 +: 8] : old_word[i*8 +: 8];
    end
  endgenerate

endmodule // lane_merge

//--- bench/flash_array_model.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Flash array stand-in
// ------------------------------------------------------------
// Goes busy on each launch pulse and ends with a one-cycle done pulse.
// The latency is long enough that the bench can poke the unit mid-run.
module flash_array_model #(
  parameter int LAT = 20
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic flash_start,
  output logic flash_busy,
  output logic flash_done
);
  // Cycles left in the running operation.
  int cnt;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      flash_busy <= 1'b0;
      flash_done <= 1'b0;
    end else begin
      flash_done <= (cnt == 1);
      if (flash_start) begin
        cnt <= LAT;
        flash_busy <= 1'b1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
        flash_busy <= (cnt > 1);
      end
    end
  end
endmodule // flash_array_model

//--- bench/flash_command_register_unit_asserts.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Launch checker
// ------------------------------------------------------------
module flash_cmd_checker #(
  parameter REGION_SHIFT = 12,
  parameter ROW_SHIFT = 8,
  parameter [22:0] USER_ROW_BYTE_ADDR = 23'h400000
) (
  input wire mclk,
  input wire rst_b,
  input wire ce,
  input wire sysbus_busy,
  input wire security_bit,
  input wire [15:0] lock_bits,
  input wire flash_busy,
  input wire flash_done,
  input wire [31:0] prdata,
  input wire flash_start,
  input wire [6:0] flash_op,
  input wire [22:0] flash_byte_addr
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Lock bits as seen at the edge that decided the launch.
  logic [15:0] lock_q;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) lock_q <= 16'hffff;
    else lock_q <= lock_bits;
  end

  a_start_one_cycle: assert property (
    flash_start && ce |=> !flash_start) else $error("launch pulse too long");
  a_launch_when_idle: assert property (
    flash_start |-> !$past(sysbus_busy) && !$past(flash_busy))
    else $error("launch while bus or array busy");
  a_known_code: assert property (
    flash_start |-> flash_op inside {7'h02, 7'h04, 7'h05}) else $error("bad launch code");
  a_change_at_launch: assert property (
    $changed(flash_op) || $changed(flash_byte_addr) |-> flash_start)
    else $error("op or address moved without launch");
  a_locked_row_kept: assert property (
    flash_start && flash_op == 7'h02 |-> lock_q[flash_byte_addr[REGION_SHIFT+:4]])
    else $error("erase launched in locked region");
  a_aux_guarded: assert property (
    flash_start && flash_op == 7'h05 |-> !$past(security_bit) &&
    flash_byte_addr[22:ROW_SHIFT] == USER_ROW_BYTE_ADDR[22:ROW_SHIFT])
    else $error("aux erase launched when forbidden");
  a_no_start_on_done: assert property (
    flash_done |-> !flash_start) else $error("launch while command runs");
  a_frozen_on_ce: assert property (
    !ce |=> $stable(flash_start) && $stable(prdata)) else $error("state moved with ce low");
endmodule // flash_cmd_checker

bind flash_command_register_unit flash_cmd_checker #(.REGION_SHIFT(REGION_SHIFT),
  .ROW_SHIFT(ROW_SHIFT), .USER_ROW_BYTE_ADDR(USER_ROW_BYTE_ADDR)) chk_u (.mclk, .rst_b,
  .ce, .sysbus_busy, .security_bit, .lock_bits, .flash_busy, .flash_done, .prdata,
  .flash_start, .flash_op, .flash_byte_addr);

//--- bench/flash_command_register_unit_bench.sv
`timescale 1ns/10ps

// ------------------------------------------------------------
// Bench top
// ------------------------------------------------------------
module flash_command_register_unit_bench;
  logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic module_enable = 1'b0, sysbus_busy = 1'b0, security_bit = 1'b0, page_loaded = 1'b0;
  logic [15:0] lock_bits = 16'hffff;
  logic pready, flash_busy, flash_done, flash_start;
  logic [6:0] flash_op;
  logic [22:0] flash_byte_addr;
  int n_errors = 0, compares = 0, n_starts = 0, cyc = 0;

  flash_command_register_unit dut_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .module_enable(module_enable),
    .sysbus_busy(sysbus_busy), .security_bit(security_bit), .lock_bits(lock_bits),
    .page_loaded(page_loaded), .flash_busy(flash_busy), .flash_done(flash_done),
    .flash_start(flash_start), .flash_op(flash_op), .flash_byte_addr(flash_byte_addr));
  flash_array_model arr_u (.mclk(mclk), .rst_b(rst_b), .flash_start(flash_start),
    .flash_busy(flash_busy), .flash_done(flash_done));

  initial forever #2.5 mclk = ~mclk;

  // Launch counter, and a ceiling that cuts a hang short.
  always @(posedge mclk) begin
    if (flash_start === 1'b1) n_starts <= n_starts + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end

  task print_verdict;
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One bus transfer; the request holds until the edge that sees ready.
  task bus(input logic w, input logic [5:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge mclk); #1;
    psel = 1'b1; pwrite = w; paddr = a; pstrb = s; pwdata = d; penable = 1'b0;
    @(posedge mclk); #1;
    penable = 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    #1;
    psel = 1'b0; penable = 1'b0;
  endtask

  task rd(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 4'h0, 32'h00000000);
    chk("read data", prdata, exp);
  endtask

  // Waits for the launch pulse, then checks it and its code and byte address.
  task launch(input logic [6:0] op, input logic [22:0] ba);
    int k;
    k = 0;
    while (flash_start !== 1'b1 && k < 60) begin @(posedge mclk); #1; k++; end
    chk("launch", {31'h0, flash_start}, 32'h00000001);
    chk("op", {25'h0, flash_op}, {25'h0, op});
    chk("byte addr", {9'h0, flash_byte_addr}, {9'h0, ba});
  endtask

  task idle;
    int k;
    k = 0;
    @(posedge mclk); #1;
    while (flash_busy !== 1'b0 && k < 60) begin @(posedge mclk); #1; k++; end
  endtask

  // A command that must be refused with the given status.
  task cmd_err(input logic [3:0] s, input logic [15:0] c, input logic [31:0] st);
    int s0;
    s0 = n_starts;
    bus(1'b1, 6'h00, s, {16'h0000, c});
    rd(6'h18, st);
    chk("launch count", n_starts, s0);
    bus(1'b1, 6'h18, 4'h1, 32'h0000000c);
    bus(1'b1, 6'h14, 4'h1, 32'h00000002);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
    rd(6'h00, 32'h00000000);
    rd(6'h08, 32'h02030400);
    rd(6'h14, 32'h00000001);
    rd(6'h20, 32'h0000ffff);
    rd(6'h24, 32'h00000000);
    ce = 1'b0;
    repeat (3) @(posedge mclk);
    // A frozen block must hold off the bus by keeping ready low.
    chk("pready frozen", {31'h0, pready}, 32'h00000000);
    #1 ce = 1'b1;
    module_enable = 1'b1;
    bus(1'b1, 6'h04, 4'hf, 32'hffffffff);
    rd(6'h04, 32'h00000080);
    module_enable = 1'b0;
    bus(1'b1, 6'h04, 4'hf, 32'hffffffff);
    rd(6'h04, 32'h0007039e);
    bus(1'b1, 6'h1c, 4'h1, 32'h00000080);
    bus(1'b1, 6'h1c, 4'h2, 32'h00000800);
    rd(6'h1c, 32'h00000880);
    sysbus_busy = 1'b1;
    bus(1'b1, 6'h00, 4'h3, 32'h0000a502);
    rd(6'h00, 32'h0000a502);
    rd(6'h14, 32'h00000000);
    chk("held launch", n_starts, 0);
    sysbus_busy = 1'b0;
    launch(7'h02, 23'h001100);
    idle;
    rd(6'h14, 32'h00000001);
    // Once issued, the key field no longer reads back its low bit.
    rd(6'h00, 32'h00000002);
    page_loaded = 1'b1;
    bus(1'b1, 6'h00, 4'h3, 32'h0000a504);
    launch(7'h04, 23'h001100);
    bus(1'b1, 6'h00, 4'h3, 32'h0000a502);
    rd(6'h18, 32'h00000006);
    rd(6'h14, 32'h00000002);
    idle;
    cmd_err(4'h3, 16'h0000, 32'h00000006);
    page_loaded = 1'b0;
    cmd_err(4'h3, 16'h5a02, 32'h00000004);
    cmd_err(4'h2, 16'ha500, 32'h00000000);
    cmd_err(4'h3, 16'ha503, 32'h00000004);
    lock_bits = 16'hfffd;
    cmd_err(4'h3, 16'ha502, 32'h00000008);
    lock_bits = 16'hffff;
    bus(1'b1, 6'h1c, 4'hf, 32'h00200000);
    security_bit = 1'b1;
    cmd_err(4'h3, 16'ha505, 32'h00000104);
    security_bit = 1'b0;
    // Software only issues once the ready flag reads one again.
    rd(6'h14, 32'h00000001);
    bus(1'b1, 6'h00, 4'h3, 32'h0000a505);
    launch(7'h05, 23'h400000);
    idle;
    chk("total launches", n_starts, 3);
    print_verdict;
  end
endmodule // flash_command_register_unit_bench
